//--- adcsc_pkg.sv
// constants and carrier types of the converter status/control bank
// assumes one clock domain and a serial front end sampled on clk_sys
package adcsc_pkg;

  // -----------------------------------------------------------------
  // register selects
  // -----------------------------------------------------------------
  localparam logic [5:0] ADCSC_RS_STATUS  = 6'h00;
  localparam logic [5:0] ADCSC_RS_CONTROL = 6'h01;
  localparam logic [5:0] ADCSC_RS_DATA    = 6'h02;
  localparam logic [5:0] ADCSC_RS_ERROR   = 6'h06;

  // -----------------------------------------------------------------
  // widths, reset values, field positions
  // -----------------------------------------------------------------
  localparam int          ADCSC_CMD_W      = 8;
  localparam int          ADCSC_STAT_W     = 8;
  localparam int          ADCSC_CTRL_W     = 16;
  localparam int          ADCSC_DATA_W     = 24;
  localparam int          ADCSC_ERR_W      = 8;
  localparam int          ADCSC_SHIFT_W    = 32;
  localparam logic [15:0] ADCSC_CTRL_RESET = 16'h0000;
  localparam int          ADCSC_CTRL_DSTAT = 10;
  localparam int          ADCSC_CTRL_CONT  = 11;
  localparam logic [5:0]  ADCSC_LEN_CMD    = 6'h08;
  localparam logic [5:0]  ADCSC_LEN_STAT   = 6'h08;
  localparam logic [5:0]  ADCSC_LEN_CTRL   = 6'h10;
  localparam logic [5:0]  ADCSC_LEN_DATA   = 6'h18;
  localparam logic [5:0]  ADCSC_LEN_ERR    = 6'h08;

  // command byte as shifted in, bit 7 first
  typedef struct packed {
    logic       wen_n;
    logic       rd;
    logic [5:0] sel;
  } adcsc_cmd_t;

  // status byte layout
  typedef struct packed {
    logic       not_ready;
    logic       err_any;
    logic       zero;
    logic       por;
    logic [3:0] channel;
  } adcsc_stat_t;

  // frame phases, one-hot
  typedef enum logic [2:0] {
    ADCSC_ST_CMD  = 3'b001,
    ADCSC_ST_WR   = 3'b010,
    ADCSC_ST_RD   = 3'b100
  } adcsc_state_t;

endpackage

//--- adcsc_regs.sv
// status byte and control register of the converter, serial access
// assumes sclk, din and cs_n already synchronous to clk_sys, and
// conversion events arriving as one-cycle pulses from the core
`timescale 1ns/100ps

module adcsc_regs
(
  // clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         arst_n,
  // serial pins, sampled
  input  wire logic                         sclk,
  input  wire logic                         din,
  input  wire logic                         cs_n,
  output logic                              dout_rdy,
  // converter core events
  input  wire logic                         result_valid,
  input  wire logic [adcsc_pkg::ADCSC_DATA_W-1:0] result_data,
  input  wire logic                         pre_update,
  input  wire logic [3:0]                   conv_channel,
  input  wire logic                         low_power_state,
  input  wire logic                         powered_down,
  input  wire logic                         supply_low,
  // error register, kept elsewhere
  input  wire logic [adcsc_pkg::ADCSC_ERR_W-1:0]  error_bits,
  output logic                              error_read,
  // control register contents
  output logic [adcsc_pkg::ADCSC_CTRL_W-1:0] converter_control,
  // status byte as seen by the host
  output adcsc_pkg::adcsc_stat_t            conversion_state
);
  import adcsc_pkg::*;

  // -----------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------
  adcsc_state_t                state_reg;
  adcsc_state_t                state_next;
  logic                        sclk_reg;
  logic                        rise;
  logic [5:0]                  cnt_reg;
  logic [5:0]                  cnt_next;
  logic [5:0]                  len_reg;
  logic [5:0]                  len_next;
  logic [ADCSC_SHIFT_W-1:0]    sh_reg;
  logic [ADCSC_SHIFT_W-1:0]    sh_next;
  logic [ADCSC_CMD_W-1:0]      cmd_shift;
  adcsc_cmd_t                  cmd_reg;
  adcsc_cmd_t                  cmd_next;
  logic                        cmd_done;
  logic                        frame_end;
  logic                        ctrl_wr;
  logic                        stat_rd;
  logic                        data_rd;
  logic                        err_rd;
  logic                        not_ready_reg;
  logic                        err_reg;
  logic                        por_reg;
  logic [3:0]                  chan_reg;
  logic                        pd_reg;
  logic [ADCSC_DATA_W-1:0]     data_reg;
  logic [ADCSC_CTRL_W-1:0]     ctrl_reg;
  logic                        dout_reg;
  logic                        dout_next;
  logic                        err_rd_reg;
  adcsc_stat_t                 stat_now;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  // place a field at the top of the shifter so it leaves msb first
  function automatic logic [ADCSC_SHIFT_W-1:0] top_align
  (
    input logic [ADCSC_SHIFT_W-1:0] val,
    input logic [5:0]               len
  );
    logic [5:0] gap;
    gap = 6'(ADCSC_SHIFT_W) - len;
    return val << gap;
  endfunction

  // -----------------------------------------------------------------
  // serial edge detect
  // -----------------------------------------------------------------
  // pins count as synchronous, so one flop is enough for the edge
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      sclk_reg <= 1'b1;
    else
      sclk_reg <= sclk;
  end

  assign rise = sclk & ~sclk_reg & ~cs_n;

  // live status byte, bit 5 tied low
  always_comb
  begin
    stat_now.not_ready = not_ready_reg;
    stat_now.err_any   = err_reg;
    stat_now.zero      = 1'b0;
    stat_now.por       = por_reg;
    stat_now.channel   = chan_reg;
  end

  assign cmd_shift = {cmd_reg[ADCSC_CMD_W-2:0], din};

  // -----------------------------------------------------------------
  // frame sequencer
  // -----------------------------------------------------------------
  // command byte, then data shifted msb first in either direction
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    len_next   = len_reg;
    sh_next    = sh_reg;
    cmd_next   = cmd_reg;
    dout_next  = dout_reg;
    cmd_done   = 1'b0;
    frame_end  = 1'b0;
    if (cs_n)
    begin
      // a deasserted select abandons any partial transfer
      state_next = ADCSC_ST_CMD;
      cnt_next   = 6'h00;
      dout_next  = not_ready_reg;
    end
    else
    begin
      case (state_reg)
        ADCSC_ST_CMD:
        begin
          if (!rise)
            dout_next = not_ready_reg;
          else if (cnt_reg == 6'h00 && din)
            cnt_next = 6'h00;                   // wen high: hold position
          else
          begin
            cmd_next = adcsc_cmd_t'(cmd_shift);
            cnt_next = cnt_reg + 6'h01;
            if (cnt_reg + 6'h01 == ADCSC_LEN_CMD)
            begin
              cmd_done = 1'b1;
              cnt_next = 6'h00;
            end
          end
          if (cmd_done)
          begin
            if (cmd_next.rd)
            begin
              state_next = ADCSC_ST_RD;
              if (cmd_next.sel == ADCSC_RS_STATUS)
              begin
                len_next = ADCSC_LEN_STAT;
                sh_next  = top_align(32'(stat_now), ADCSC_LEN_STAT);
              end
              else if (cmd_next.sel == ADCSC_RS_CONTROL)
              begin
                len_next = ADCSC_LEN_CTRL;
                sh_next  = top_align(32'(ctrl_reg), ADCSC_LEN_CTRL);
              end
              else if (cmd_next.sel == ADCSC_RS_DATA
                       && ctrl_reg[ADCSC_CTRL_DSTAT])
              begin
                // status byte rides after the result
                len_next = ADCSC_LEN_DATA + ADCSC_LEN_STAT;
                sh_next  = {data_reg, 8'(stat_now)};
              end
              else if (cmd_next.sel == ADCSC_RS_DATA)
              begin
                len_next = ADCSC_LEN_DATA;
                sh_next  = top_align(32'(data_reg), ADCSC_LEN_DATA);
              end
              else if (cmd_next.sel == ADCSC_RS_ERROR)
              begin
                len_next = ADCSC_LEN_ERR;
                sh_next  = top_align(32'(error_bits), ADCSC_LEN_ERR);
              end
              else
              begin
                // unmapped selects read back zeros
                len_next = ADCSC_LEN_STAT;
                sh_next  = '0;
              end
              dout_next = sh_next[ADCSC_SHIFT_W-1];
            end
            else
            begin
              state_next = ADCSC_ST_WR;
              // status is read-only: its write is a byte thrown away
              len_next = (cmd_next.sel == ADCSC_RS_CONTROL)
                         ? ADCSC_LEN_CTRL : ADCSC_LEN_STAT;
              sh_next  = '0;
            end
          end
        end
        ADCSC_ST_WR:
        begin
          if (rise)
          begin
            sh_next  = {sh_reg[ADCSC_SHIFT_W-2:0], din};
            cnt_next = cnt_reg + 6'h01;
            if (cnt_reg + 6'h01 == len_reg)
            begin
              frame_end  = 1'b1;
              cnt_next   = 6'h00;
              state_next = ADCSC_ST_CMD;
            end
          end
        end
        ADCSC_ST_RD:
        begin
          if (rise)
          begin
            sh_next   = {sh_reg[ADCSC_SHIFT_W-2:0], 1'b0};
            dout_next = sh_next[ADCSC_SHIFT_W-1];
            cnt_next  = cnt_reg + 6'h01;
            if (cnt_reg + 6'h01 == len_reg)
            begin
              frame_end  = 1'b1;
              cnt_next   = 6'h00;
              state_next = ADCSC_ST_CMD;
              dout_next  = not_ready_reg;
            end
          end
        end
        default:
        begin
          state_next = ADCSC_ST_CMD;
          cnt_next   = 6'h00;
        end
      endcase
    end
  end

  // accesses qualified by their command: writes, data and error reads at frame end, status reads at command end
  assign ctrl_wr = frame_end && state_reg == ADCSC_ST_WR
                   && cmd_reg.sel == ADCSC_RS_CONTROL;
  assign stat_rd = cmd_done && cmd_next.rd
                   && cmd_next.sel == ADCSC_RS_STATUS;
  assign data_rd = frame_end && state_reg == ADCSC_ST_RD
                   && cmd_reg.sel == ADCSC_RS_DATA;
  assign err_rd  = frame_end && state_reg == ADCSC_ST_RD
                   && cmd_reg.sel == ADCSC_RS_ERROR;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= ADCSC_ST_CMD;
      cnt_reg   <= 6'h00;
      len_reg   <= ADCSC_LEN_STAT;
      sh_reg    <= '0;
      cmd_reg   <= '0;
      dout_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      len_reg   <= len_next;
      sh_reg    <= sh_next;
      cmd_reg   <= cmd_next;
      dout_reg  <= dout_next;
    end
  end

  // -----------------------------------------------------------------
  // control register
  // -----------------------------------------------------------------
  // all sixteen bits stored as written; the top three are the host's
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      ctrl_reg <= ADCSC_CTRL_RESET;
    else if (ctrl_wr)
      ctrl_reg <= sh_next[ADCSC_CTRL_W-1:0];
  end

  // -----------------------------------------------------------------
  // status flags
  // -----------------------------------------------------------------
  // not-ready: any set source beats a same-cycle clear
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      not_ready_reg <= 1'b0;
    else if (low_power_state)
      not_ready_reg <= 1'b1;
    else if (data_rd || pre_update)
      not_ready_reg <= 1'b1;
    else if (result_valid)
      not_ready_reg <= 1'b0;
  end

  // latest result, held for the data register read
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      data_reg <= '0;
    else if (result_valid)
      data_reg <= result_data;
  end

  // error summary follows new error bits, cleared by error read
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      err_reg <= 1'b0;
    else if (|error_bits && !err_rd_reg)
      err_reg <= 1'b1;
    else if (err_rd)
      err_reg <= 1'b0;
  end

  // power-down history for the exit edge
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      pd_reg <= 1'b0;
    else
      pd_reg <= powered_down;
  end

  // reset flag comes up set, since every reset counts as one
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      por_reg <= 1'b1;
    else if (supply_low || (pd_reg && !powered_down))
      por_reg <= 1'b1;
    else if (stat_rd)
      por_reg <= 1'b0;
  end

  // channel code tracks the core
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      chan_reg <= 4'h0;
    else
      chan_reg <= conv_channel;
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  // error read pulse lets the error register clear its own flags;
  // it also masks the summary set for the cycle the bits drop
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      err_rd_reg <= 1'b0;
    else
      err_rd_reg <= err_rd;
  end

  assign error_read        = err_rd_reg;
  assign dout_rdy          = dout_reg;
  assign converter_control = ctrl_reg;
  assign conversion_state  = {not_ready_reg, err_reg, 1'b0,
                              por_reg, chan_reg};

endmodule

//--- adcsc_regs_sva.sv
// assertions on the ports of the status/control bank
// assumes one clk_sys domain and a bind into every adcsc_regs
`timescale 1ns/100ps

module adcsc_regs_chk
  import adcsc_pkg::*;
(
  // clock and reset
  input wire logic                           clk_sys,
  input wire logic                           arst_n,
  // serial side and core events
  input wire logic                           cs_n,
  input wire logic                           dout_rdy,
  input wire logic                           result_valid,
  input wire logic                           pre_update,
  input wire logic [3:0]                     conv_channel,
  input wire logic                           low_power_state,
  input wire logic                           powered_down,
  input wire logic [adcsc_pkg::ADCSC_ERR_W-1:0]  error_bits,
  input wire logic                           error_read,
  // register contents
  input wire logic [adcsc_pkg::ADCSC_CTRL_W-1:0] converter_control,
  input wire adcsc_pkg::adcsc_stat_t         conversion_state
);
  // ---------------------------------------------------------------
  // status flags, pin and control register
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  a_bit5_zero: assert property (!conversion_state.zero)
    else $error("status bit 5 not zero");
  a_lowpwr_busy: assert property (low_power_state |=>
    conversion_state.not_ready) else $error("not-ready not forced");
  a_result_clear: assert property (result_valid && cs_n && !pre_update
    && !low_power_state |=> !conversion_state.not_ready)
    else $error("new result left not-ready set");
  a_preupd_set: assert property (pre_update |=>
    conversion_state.not_ready) else $error("pre-update missed");
  // pin may lag the flag by a cycle, so only a settled flag is compared
  a_pin_ready: assert property (cs_n && $past(cs_n)
    && $stable(conversion_state.not_ready)
    |-> dout_rdy == conversion_state.not_ready)
    else $error("ready pin differs from flag");
  a_err_sets: assert property ((|error_bits) [*3] ##0 !error_read
    ##0 !$past(error_read) ##0 !$past(error_read, 2)
    |-> conversion_state.err_any) else $error("error summary low");
  a_err_clear: assert property (error_read && !(|error_bits)
    && !(|$past(error_bits)) |=> !conversion_state.err_any)
    else $error("error summary kept after read");
  a_por_wake: assert property ($fell(powered_down) |-> ##[0:1]
    conversion_state.por) else $error("reset flag not set on wake");
  a_chan_track: assert property ($past(arst_n) && $stable(conv_channel)
    |-> conversion_state.channel == conv_channel)
    else $error("channel code wrong");
  a_ctrl_quiet: assert property (cs_n |=>
    $stable(converter_control)) else $error("control changed idle");

  c_error_read: cover property (error_read);
  c_result: cover property (result_valid);
  c_wake: cover property ($fell(powered_down));
endmodule

bind adcsc_regs adcsc_regs_chk chk_u
(
  .clk_sys(clk_sys), .arst_n(arst_n), .cs_n(cs_n), .dout_rdy(dout_rdy),
  .result_valid(result_valid), .pre_update(pre_update),
  .conv_channel(conv_channel), .low_power_state(low_power_state),
  .powered_down(powered_down), .error_bits(error_bits),
  .error_read(error_read), .converter_control(converter_control),
  .conversion_state(conversion_state)
);

//--- adcsc_host.sv
// serial host model: one framed command plus data, msb first
// assumes the bench calls frame() and may stretch half
`timescale 1ns/100ps

module adcsc_host
(
  // clock
  input  wire logic clk_sys,
  // serial pins
  output logic      sclk,
  output logic      din,
  output logic      cs_n,
  input  wire logic dout_rdy
);
  int half = 2; // clk cycles per sclk phase, never below two

  // clock parks high outside frames so no stray rise is seen
  initial
  begin
    sclk = 1'b1;
    din  = 1'b0;
    cs_n = 1'b1;
  end

  // read bits are taken at the end of each high phase, after the rise has landed
  // wide enough for a command, a result and the trailing status byte
  task automatic frame(input logic [63:0] v, input int n,
                       output logic [63:0] rd);
    rd = 64'h0000000000000000;
    @(negedge clk_sys) cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      repeat (half) @(negedge clk_sys);
      rd[i] = dout_rdy;
      sclk = 1'b0;
      din = v[i];
      repeat (half) @(negedge clk_sys);
      sclk = 1'b1;
    end
    repeat (half) @(negedge clk_sys);
    cs_n = 1'b1;
    din = 1'b0; // din low between frames
    repeat (2) @(negedge clk_sys);
  endtask
endmodule

//--- tb_adcsc_regs.sv
// self-checking bench for the converter status/control bank
// assumes adcsc_host on the serial pins and the bound checker
`timescale 1ns/100ps

module tb_adcsc_regs;
  import adcsc_pkg::*;

  // ---------------------------------------------------------------
  // signals and reference state
  // ---------------------------------------------------------------
  logic        clk_sys = 1'b0;
  logic        arst_n = 1'b0;
  logic        sclk, din, cs_n, dout_rdy, error_read;
  logic        result_valid = 1'b0, pre_update = 1'b0, supply_low = 1'b0;
  logic        low_power_state = 1'b0, powered_down = 1'b0;
  logic [23:0] result_data = 24'h000000;
  logic [3:0]  conv_channel = 4'h0;
  logic [7:0]  error_bits = 8'h00;
  logic [15:0] converter_control, val, lfsr = 16'hAD61;
  logic [15:0] ctl_q[$];
  logic [63:0] rd;
  logic [7:0]  est;
  int          n_erd = 0;
  adcsc_stat_t conversion_state;
  int          n_fail = 0, comparisons = 0;
  int          exp_nr = 0, exp_err = 0, exp_por = 1;

  always #10 clk_sys = ~clk_sys;

  // error read pulses, counted so a missing or doubled pulse shows
  always @(posedge clk_sys)
    if (error_read === 1'b1)
      n_erd++;

  adcsc_host host_u
  (
    .clk_sys(clk_sys), .sclk(sclk), .din(din), .cs_n(cs_n),
    .dout_rdy(dout_rdy)
  );

  adcsc_regs dut_u
  (
    .clk_sys(clk_sys), .arst_n(arst_n), .sclk(sclk), .din(din),
    .cs_n(cs_n), .dout_rdy(dout_rdy), .result_valid(result_valid),
    .result_data(result_data), .pre_update(pre_update),
    .conv_channel(conv_channel), .low_power_state(low_power_state),
    .powered_down(powered_down), .supply_low(supply_low),
    .error_bits(error_bits), .error_read(error_read),
    .converter_control(converter_control),
    .conversion_state(conversion_state)
  );

  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // expected status byte from the reference flags
  function automatic logic [7:0] st();
    return {exp_nr[0], exp_err[0], 1'b0, exp_por[0], conv_channel};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic results;
    if (n_fail == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // one-cycle core event: 0 result, 1 pre-update, 2 low supply
  task automatic pulse(input int w);
    result_valid = (w == 0);
    pre_update = (w == 1);
    supply_low = (w == 2);
    wait_n(1);
    {result_valid, pre_update, supply_low} = 3'b000;
    wait_n(2);
  endtask

  // snapshot is taken at command end, so expect flags from before
  task automatic stat_read;
    logic [7:0] e;
    e = st();
    // leading high enable bit must be skipped before the command
    host_u.frame({1'b1, 8'h40, 8'h00}, 17, rd);
    exp_por = 0;
    chk(rd[7:0], e);
    chk(conversion_state, st());
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    wait_n(20);
    arst_n = 1'b1;
    wait_n(2);
    chk(converter_control, 16'h0000);
    chk(conversion_state, st());
    // control round trips, host slowed on each pass
    for (int k = 0; k < 4; k++)
    begin
      lfsr = nxt(lfsr);
      host_u.half = 2 + k;
      val = {3'b000, lfsr[12:0]};
      ctl_q.push_back(val);
      host_u.frame({8'h01, val}, 24, rd);
      chk(converter_control, val);
      host_u.frame({8'h41, 16'h0000}, 24, rd);
      chk(rd[15:0], ctl_q.pop_front());
    end
    host_u.frame({8'h01, 16'h0000}, 24, rd);
    for (int c = 0; c < 16; c++)
    begin
      conv_channel = c[3:0];
      wait_n(2);
      chk(conversion_state, st());
    end
    host_u.frame({8'h00, lfsr[7:0]}, 16, rd);
    chk(conversion_state, st());
    conv_channel = lfsr[11:8];
    stat_read();
    stat_read();
    error_bits = lfsr[7:0] | 8'h01;
    wait_n(3);
    exp_err = 1;
    chk(conversion_state, st());
    error_bits = 8'h00;
    host_u.frame({8'h46, 8'h00}, 16, rd);
    exp_err = 0;
    chk(conversion_state, st());
    chk(rd[7:0], error_bits);
    chk(n_erd, 1);
    result_data = {lfsr, lfsr[15:8]};
    pulse(0);
    chk(dout_rdy, 1'b0);
    host_u.frame({8'h42, 24'h000000}, 32, rd);
    exp_nr = 1;
    chk(rd[23:0], result_data);
    chk(conversion_state, st());
    pulse(0);
    exp_nr = 0;
    chk(conversion_state, st());
    chk(dout_rdy, 1'b0);
    // result read with the status byte riding behind it
    host_u.frame({8'h01, 16'h0400}, 24, rd);
    chk(converter_control, 16'h0400);
    est = st();
    host_u.frame({8'h42, 32'h00000000}, 40, rd);
    exp_nr = 1;
    chk(rd[31:8], result_data);
    chk(rd[7:0], est);
    chk(conversion_state, st());
    pulse(1);
    exp_nr = 1;
    chk(dout_rdy, 1'b1);
    pulse(0);
    low_power_state = 1'b1;
    wait_n(2);
    chk(conversion_state, st());
    low_power_state = 1'b0;
    powered_down = 1'b1;
    wait_n(3);
    powered_down = 1'b0;
    wait_n(2);
    exp_por = 1;
    chk(conversion_state.por, 1'b1);
    stat_read();
    pulse(2);
    chk(conversion_state.por, 1'b1);
    host_u.frame({8'h01, 16'h1A5C}, 24, rd);
    chk(converter_control, 16'h1A5C);
    arst_n = 1'b0;
    wait_n(3);
    arst_n = 1'b1;
    wait_n(2);
    chk(converter_control, 16'h0000);
    chk(conversion_state.por, 1'b1);
    results();
  end

  // hang guard, well past the few thousand cycles the tests need
  initial
  begin
    #1500000;
    n_fail++;
    results();
  end
endmodule
